// ===== dv/host_model.sv
/*
  host serial port model: frames characters onto rxd, collects characters from txd.
  assumes: the bench drives dsr itself; txd is only sent at the fast rate.
*/
module host_model #(
  parameter int BIT = 8  // clocks per bit on the receive side
) (
  input  wire logic mclk,  // system clock
  output logic      rxd,   // line into the device
  input  wire logic txd,   // line from the device
  input  wire logic dtr    // device hold-off
);
  timeunit 1ns;
  timeprecision 1ps;
  int         late = 0;  // dtr waits that ran out, counted as mismatches by the bench
  logic [7:0] rx_q[$];
  logic [7:0] c;
  int         i;
  // line idles high between frames
  initial rxd = 1'b1;
  // waits on dtr unless told to push into the grace window
  task automatic send(input logic [7:0] ch, input int bc, input bit nowait);
    int k;
    logic [10:0] f;
    f = {2'b11, ch, 1'b0};
    for (k = 0; k < 3000 && !nowait && dtr !== 1'b1; k++)
      @(posedge mclk);
    if (!nowait && dtr !== 1'b1)
      late++;
    for (k = 0; k < 11; k++)
    begin
      @(posedge mclk);
      rxd <= f[k];
      repeat (bc - 1) @(posedge mclk);
    end
  endtask : send
  // mid-bit sampling of each outgoing character, lsb first
  initial forever
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge mclk);
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge mclk);
      c[i] = txd;
    end
    rx_q.push_back(c);
  end
endmodule : host_model

// ===== dv/serial_dtr_dsr_flow_control_tb.sv
/*
  bench for the serial flow-control block: apb master, host model, scenario tasks.
  assumes: shortened counts (8 clocks per bit, drop at 4, resume at 2, grace 2).
*/
`include "serial_regs.svh"
module serial_dtr_dsr_flow_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_pkg::*;
  localparam int BIT = 8;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, rxd, txd, dsr, dtr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_count, tests_run, i;
  host_model #(.BIT(BIT)) hm (.mclk, .rxd, .txd, .dtr);
  serial_flow_ctrl #(.FIFO_DEPTH(8), .FULL_LEVEL(4), .RESUME_LEVEL(2), .GRACE_CHARS(2),
    .BIT_CYC_FAST(20'h8)) dut (.mclk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .dsr, .dtr);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic summarize();
    err_count += hm.late;
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one transfer; pready, read data and slverr are all taken at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      err_count++;
      summarize();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_q(input int n);
    int k;
    for (k = 0; k < 4000 && hm.rx_q.size() < n; k++)
      @(posedge mclk);
    if (hm.rx_q.size() < n)
    begin
      err_count++;
      summarize();
    end
  endtask : wait_q
  task automatic t_regs();
    apb(0, `OFF_CTRL, 0);
    chk("ctrl", 32'h5, rd);
    apb(0, `OFF_STATUS, 0);
    chk("status", 32'h500, rd);
    apb(0, 12'h010, 0);
    chk("slverr", 32'h1, 32'(se));
  endtask : t_regs
  // every rate, then seven-bit even and odd parity
  task automatic t_baud();
    for (i = 0; i < 6; i++)
    begin
      apb(1, `OFF_CTRL, i);
      hm.send(8'h60 + i, BIT << (5 - i), 0);
      apb(0, `OFF_RXDATA, 0);
      chk("rx_baud", 32'h160 + i, rd);
    end
    apb(1, `OFF_CTRL, 32'hd);
    hm.send(8'hc3, BIT, 0);
    apb(0, `OFF_RXDATA, 0);
    chk("rx_par", 32'h143, rd);
    apb(1, `OFF_CTRL, 32'h15);
    hm.send(8'hc1, BIT, 0);
    apb(0, `OFF_RXDATA, 0);
    chk("rx_odd", 32'h141, rd);
    apb(0, `OFF_STATUS, 0);
    chk("perr", 32'h0, rd & 32'h4000);
    apb(1, `OFF_CTRL, 32'h5);
  endtask : t_baud
  task automatic t_full();
    for (i = 0; i < 4; i++)
      hm.send(8'h30 + i, BIT, 0);
    repeat (4) @(posedge mclk);
    chk("dtr_full", 32'h0, 32'(dtr));
    hm.send(8'h34, BIT, 1);
    hm.send(8'h35, BIT, 1);
    apb(0, `OFF_STATUS, 0);
    chk("cnt_grace", 32'h6, rd & 32'hff);
    for (i = 0; i < 6; i++)
    begin
      apb(0, `OFF_RXDATA, 0);
      chk("rx_fifo", 32'h130 + i, rd);
      repeat (3) @(posedge mclk);
      if (i == 3)
        chk("dtr_resume", 32'h1, 32'(dtr));
    end
  endtask : t_full
  task automatic t_dsr();
    @(posedge mclk);
    dsr <= 1'b0;
    apb(1, `OFF_TXDATA, 32'h11);
    apb(1, `OFF_TXDATA, 32'h22);
    repeat (100) @(posedge mclk);
    chk("tx_held", 32'h0, 32'(hm.rx_q.size()));
    chk("dtr_susp", 32'h0, 32'(dtr));
    dsr <= 1'b1;
    wait_q(2);
    chk("tx_first", 32'h11, 32'(hm.rx_q[0]));
    chk("tx_second", 32'h22, 32'(hm.rx_q[1]));
    hm.rx_q.delete();
  endtask : t_dsr
  // response held until newline, dtr low across it
  task automatic t_talk();
    apb(1, `OFF_CTRL, 32'h25);
    apb(1, `OFF_TXDATA, 32'h14f);
    repeat (100) @(posedge mclk);
    chk("talk_wait", 32'h0, 32'(hm.rx_q.size()));
    hm.send(`CHAR_NL, BIT, 0);
    repeat (4) @(posedge mclk);
    chk("dtr_talk", 32'h0, 32'(dtr));
    wait_q(1);
    chk("tx_talk", 32'h4f, 32'(hm.rx_q[0]));
    repeat (24) @(posedge mclk);
    chk("dtr_done", 32'h1, 32'(dtr));
    apb(0, `OFF_RXDATA, 0);
    chk("rx_nl", 32'h10a, rd);
    hm.rx_q.delete();
  endtask : t_talk
  // deadlock broken: dsr dropped first, then the abort character
  task automatic t_abort();
    @(posedge mclk);
    dsr <= 1'b0;
    apb(1, `OFF_TXDATA, 32'h155);
    repeat (10) @(posedge mclk);
    chk("dtr_dead", 32'h0, 32'(dtr));
    hm.send(`CHAR_ETX, BIT, 1);
    @(posedge mclk);
    dsr <= 1'b1;
    repeat (200) @(posedge mclk);
    chk("tx_flushed", 32'h0, 32'(hm.rx_q.size()));
    apb(0, `OFF_STATUS, 0);
    chk("status_abort", 32'h1500, rd);
    apb(1, `OFF_STATUS, 32'h1000);
    apb(0, `OFF_STATUS, 0);
    chk("abort_clr", 32'h500, rd);
  endtask : t_abort
  initial
  begin
    err_count = 0;
    tests_run = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    dsr = 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_baud();
    t_full();
    t_dsr();
    t_talk();
    t_abort();
    summarize();
  end
endmodule : serial_dtr_dsr_flow_control_tb

// ===== dv/serial_flow_ctrl_chk.sv
/*
  port checker for the serial flow-control block: apb handshake and txd framing.
  assumes: bound into serial_flow_ctrl; BIT is clocks per bit at the fast rate and tx runs only there.
*/
`include "serial_regs.svh"
module serial_flow_ctrl_chk #(
  parameter int BIT = 8  // clocks per bit
) (
  input wire logic               mclk,     // system clock
  input wire logic               srst,     // synchronous reset
  input wire logic [`APB_AW-1:0] paddr,    // apb address
  input wire logic               psel,     // apb select
  input wire logic               penable,  // apb access phase
  input wire logic               pwrite,   // apb direction
  input wire logic [31:0]        prdata,   // apb read data
  input wire logic               pready,   // apb ready
  input wire logic               pslverr,  // apb error
  input wire logic               txd,      // serial out
  input wire logic               dsr,      // host ready
  input wire logic               dtr       // device ready
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 11 * BIT;
  int   tx_cnt_r;
  int   tx_cnt_nxt;
  logic tx_start;
  logic mapped;
  // a low txd outside a frame opens one; an abort mid-frame would confuse this, so benches avoid it
  assign tx_start = (tx_cnt_r == 0) && !txd;
  assign mapped = paddr inside {`OFF_CTRL, `OFF_STATUS, `OFF_RXDATA, `OFF_TXDATA};
  always_comb
  begin
    tx_cnt_nxt = tx_cnt_r;
    if (tx_start)
      tx_cnt_nxt = FRAME - 1;
    else if (tx_cnt_r != 0)
      tx_cnt_nxt = tx_cnt_r - 1;
  end
  always_ff @(posedge mclk)
  begin
    tx_cnt_r <= srst ? 0 : tx_cnt_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  AST_PREADY_FIRST: assert property (psel && penable && !$past(penable) |-> pready)
    else $error("pready missing in first access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_SLVERR: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  AST_PRDATA_IDLE: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside a read");
  AST_DTR_REL: assert property ($fell(srst) |-> ##[1:2] dtr)
    else $error("dtr not true after reset release");
  AST_TX_DSR: assert property (tx_start |-> $past(dsr))
    else $error("character started while dsr false");
  AST_TX_START_BIT: assert property (tx_cnt_r > FRAME - BIT |-> !txd)
    else $error("start bit too short");
  AST_TX_STOP: assert property (tx_cnt_r != 0 && tx_cnt_r < 2 * BIT |-> txd)
    else $error("stop bits not high");
  cover property (tx_start);
  cover property ($fell(dtr));
  cover property (pready && pslverr);
endmodule : serial_flow_ctrl_chk

bind serial_flow_ctrl serial_flow_ctrl_chk #(.BIT(int'(BIT_CYC_FAST))) u_chk (
  .mclk, .srst, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .txd, .dsr, .dtr);

// ===== hw/pair_buffer.sv
/*
  two-entry buffer with valid/ready on both sides and a flush.
  assumes: one clock; flush discards both entries and wins over a push.
*/
module pair_buffer #(
  parameter int WIDTH = 9  // entry width
) (
  input  wire logic             mclk,       // system clock
  input  wire logic             srst,       // synchronous reset
  input  wire logic             flush,      // drop everything held
  input  wire logic             in_valid,   // push request
  output logic                  in_ready,   // room for one more
  input  wire logic [WIDTH-1:0] in_data,    // pushed entry
  output logic                  out_valid,  // entry available
  input  wire logic             out_ready,  // consumer takes it
  output logic [WIDTH-1:0]      out_data    // oldest entry
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]       cnt_r, cnt_nxt;
  logic             push, pop;

  // counts, not pointer compare, give honest full and empty
  always_comb
  begin
    push = in_valid && in_ready && !flush;
    pop = out_valid && out_ready && !flush;
    wp_nxt = flush ? 1'b0 : wp_r ^ push;
    rp_nxt = flush ? 1'b0 : rp_r ^ pop;
    cnt_nxt = flush ? 2'h0 : cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push)
      mem_r[wp_r] <= in_data;
  end

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
endmodule : pair_buffer

// ===== hw/rx_frame.sv
/*
  receive framer: one start bit, eight bit slots, stop bits; flags parity and framing errors.
  assumes: rxd synchronous to mclk, idle high; bit_cyc steady during a frame.
*/
`include "serial_regs.svh"
module rx_frame (
  input  wire logic               mclk,      // system clock
  input  wire logic               srst,      // synchronous reset
  input  wire logic               rxd,       // serial input
  input  wire serial_pkg::bitcnt_t bit_cyc,  // clocks per bit
  input  wire serial_pkg::parity_t par,      // parity mode
  output logic                    vld,       // one-cycle pulse per frame
  output logic [7:0]              data,      // raw eight bit slots
  output logic                    perr,      // parity wrong, with vld
  output logic                    ferr       // first stop bit low, with vld
);
  import serial_pkg::*;

  rx_state_t  st_r, st_nxt;
  bitcnt_t    cnt_r, cnt_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic       vld_nxt, perr_nxt, ferr_nxt;

  // sample mid-bit; a start edge shorter than half a bit is dropped as a glitch
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    vld_nxt = 1'b0;
    perr_nxt = perr;
    ferr_nxt = ferr;
    case (st_r)
      RX_IDLE:
        if (!rxd)
        begin
          st_nxt = RX_START;
          cnt_nxt = bit_cyc >> 1;
        end
      RX_START:
        if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else if (rxd)
          st_nxt = RX_IDLE;
        else
        begin
          st_nxt = RX_DATA;
          cnt_nxt = bit_cyc - 1'b1;
          idx_nxt = '0;
        end
      RX_DATA:
        if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else
        begin
          sh_nxt = {rxd, sh_r[7:1]};
          cnt_nxt = bit_cyc - 1'b1;
          idx_nxt = idx_r + 1'b1;
          if (idx_r == 3'h7)
            st_nxt = RX_STOP;
        end
      RX_STOP:
        if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else
        begin
          st_nxt = RX_IDLE;  // second stop bit reads as idle
          vld_nxt = 1'b1;
          ferr_nxt = !rxd;
          perr_nxt = ((par == PAR_EVEN) && ^sh_r) || ((par == PAR_ODD) && !(^sh_r));
        end
      default:
        st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_r <= RX_IDLE;
      cnt_r <= '0;
      idx_r <= '0;
      sh_r <= '0;
      vld <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      vld <= vld_nxt;
      perr <= perr_nxt;
      ferr <= ferr_nxt;
    end
  end
  assign data = sh_r;
endmodule : rx_frame

// ===== hw/serial_flow_ctrl.sv
/*
  serial character port with DTR/DSR hold-off, receive buffer and APB registers.
  assumes: APB master per AMBA APB; rxd and dsr synchronous to mclk; dtr true = 1,
  dsr true = 1; line drivers outside do the voltage inversion.
*/
// The placing of the registers and register access over APB were left to the implementer.
// Overview of operation
// - take characters only while DTR is true; the code also takes up to GRACE_CHARS more after DTR drops
// - drop DTR at about one hundred buffered
// - raise DTR after draining, unless response pending
// - query plus newline drops DTR before response
// - raise DTR after last response character, unless full
// - check DSR before each character; false suspends
// - DSR true again resumes where output stopped
// - DTR held false while output is suspended
// - Ctrl-C aborts operation and discards pending output
// - one start bit and two stop bits
// - six baud rates, 300 up to 9600
// - no parity eight bits, else seven bits
`include "serial_regs.svh"
module serial_flow_ctrl #(
  parameter int                  FIFO_DEPTH   = `FIFO_DEPTH,    // receive buffer entries
  parameter int                  FULL_LEVEL   = `FULL_LEVEL,    // fill that drops DTR
  parameter int                  RESUME_LEVEL = `RESUME_LEVEL,  // fill that allows DTR again
  parameter int                  GRACE_CHARS  = `GRACE_CHARS,   // chars still taken after DTR drops
  parameter serial_pkg::bitcnt_t BIT_CYC_FAST = serial_pkg::bitcnt_t'(`CLK_HZ / `BAUD_FAST)  // clocks per bit
) (
  input  wire logic              mclk,     // system clock, 125 MHz
  input  wire logic              srst,     // synchronous reset, active high
  input  wire logic [`APB_AW-1:0] paddr,   // apb address
  input  wire logic              psel,     // apb select
  input  wire logic              penable,  // apb access phase
  input  wire logic              pwrite,   // apb direction
  input  wire logic [31:0]       pwdata,   // apb write data
  output logic [31:0]            prdata,   // apb read data
  output logic                   pready,   // apb ready
  output logic                   pslverr,  // apb error, unmapped address
  input  wire logic              rxd,      // serial data in
  output logic                   txd,      // serial data out
  input  wire logic              dsr,      // host ready to accept
  output logic                   dtr       // device ready, hold-off when low
);
  import serial_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] FULL_C = CW'(FULL_LEVEL);
  localparam logic [CW-1:0] RESUME_C = CW'(RESUME_LEVEL);
  localparam logic [3:0] GRACE_C = 4'(GRACE_CHARS);

  // pointers wrap by width, count must fit its status field, shifts must fit bitcnt_t
  if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || FIFO_DEPTH > 128 || FIFO_DEPTH < 4
      || FULL_LEVEL + GRACE_CHARS > FIFO_DEPTH || RESUME_LEVEL >= FULL_LEVEL
      || GRACE_CHARS > 15 || GRACE_CHARS < 1 || BIT_CYC_FAST >= bitcnt_t'(32768)
      || BIT_CYC_FAST < bitcnt_t'(4))
  begin : g_bad_params
    $error("serial_flow_ctrl: unsupported parameter set");
  end

  // configuration and flags
  logic [2:0]  baud_r, baud_nxt;
  parity_t     par_r, par_nxt;
  logic        talk_r, talk_nxt, nl_r, nl_nxt;
  logic        abort_r, abort_nxt, ovr_r, ovr_nxt;
  logic        perr_r, perr_nxt, ferr_r, ferr_nxt;
  // apb
  logic        pready_nxt, pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic        setup, acc, wr_ctrl, wr_stat, wr_tx, rd_rx;
  // receive buffer and flow
  logic [7:0]    mem_r [FIFO_DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          fill_r, fill_nxt, dtr_nxt;
  logic [3:0]    grace_r, grace_nxt;
  logic          push, pop, may_take, is_etx, is_nl, talk_hold;
  logic [7:0]    char_in;
  // transmit
  tx_state_t   tx_st_r, tx_st_nxt;
  logic [10:0] sh_r, sh_nxt;
  logic [3:0]  idx_r, idx_nxt;
  bitcnt_t     tcnt_r, tcnt_nxt, bit_cyc;
  logic        last_r, last_nxt, txd_nxt, susp_r, susp_nxt;
  logic        done_last, talk_ok, tb_take, tb_v, tb_rdy;
  logic [8:0]  tb_d;
  logic [7:0]  tx_frame_dat;
  // receiver outputs
  logic        rx_vld, rx_perr, rx_ferr;
  logic [7:0]  rx_byte;

  // baud index 0..5 = 300..9600, each step doubles the rate
  assign bit_cyc = BIT_CYC_FAST << (`BAUD_SEL_MAX - baud_r);

  rx_frame u_rx (
    .mclk    (mclk),
    .srst    (srst),
    .rxd     (rxd),
    .bit_cyc (bit_cyc),
    .par     (par_r),
    .vld     (rx_vld),
    .data    (rx_byte),
    .perr    (rx_perr),
    .ferr    (rx_ferr)
  );

  // response characters wait here; the shifter stalls on DSR so the pair can fill
  pair_buffer #(.WIDTH(9)) u_txbuf (
    .mclk      (mclk),
    .srst      (srst),
    .flush     (is_etx),
    .in_valid  (wr_tx),
    .in_ready  (tb_rdy),
    .in_data   (pwdata[`TXD_LAST:0]),
    .out_valid (tb_v),
    .out_ready (tb_take),
    .out_data  (tb_d)
  );

  // received character decode
  always_comb
  begin
    char_in = (par_r == PAR_NONE) ? rx_byte : {1'b0, rx_byte[6:0]};
    is_etx = rx_vld && !rx_ferr && (char_in == `CHAR_ETX);
    is_nl = (char_in == `CHAR_NL);
    talk_hold = talk_r && nl_r;
  end

  // apb decode: zero wait states, pready rises in the first access cycle
  always_comb
  begin
    setup = psel && !penable;
    acc = psel && penable && pready;
    wr_ctrl = acc && pwrite && (paddr == `OFF_CTRL);
    wr_stat = acc && pwrite && (paddr == `OFF_STATUS);
    wr_tx = acc && pwrite && (paddr == `OFF_TXDATA);
    rd_rx = acc && !pwrite && (paddr == `OFF_RXDATA);
    pready_nxt = setup;
    pslverr_nxt = setup && (paddr != `OFF_CTRL) && (paddr != `OFF_STATUS)
                  && (paddr != `OFF_RXDATA) && (paddr != `OFF_TXDATA);
    prdata_nxt = '0;
    if (setup && !pwrite)
    begin
      case (paddr)
        `OFF_CTRL:
        begin
          prdata_nxt[`CTRL_BAUD_HI:`CTRL_BAUD_LO] = baud_r;
          prdata_nxt[`CTRL_PAR_HI:`CTRL_PAR_LO] = par_r;
          prdata_nxt[`CTRL_TALK] = talk_r;
        end
        `OFF_STATUS:
        begin
          prdata_nxt[`ST_CNT_HI:`ST_CNT_LO] = 8'(cnt_r);
          prdata_nxt[`ST_DTR] = dtr;
          prdata_nxt[`ST_SUSP] = susp_r;
          prdata_nxt[`ST_TXRDY] = tb_rdy;
          prdata_nxt[`ST_TALK] = talk_hold;
          prdata_nxt[`ST_ABORT] = abort_r;
          prdata_nxt[`ST_OVR] = ovr_r;
          prdata_nxt[`ST_PERR] = perr_r;
          prdata_nxt[`ST_FERR] = ferr_r;
        end
        `OFF_RXDATA:
        begin
          // valid is latched here so a pop never takes a char the read did not show
          prdata_nxt[`RXD_VALID-1:0] = mem_r[rp_r];
          prdata_nxt[`RXD_VALID] = (cnt_r != '0);
        end
        default:
          prdata_nxt = '0;
      endcase
    end
  end

  // configuration, talk state and sticky flags; each sticky flag's set wins over its clear, but Ctrl-C clears talk state over a set
  always_comb
  begin
    baud_nxt = baud_r;
    par_nxt = par_r;
    if (wr_ctrl && pwdata[`CTRL_BAUD_HI:`CTRL_BAUD_LO] <= `BAUD_SEL_MAX)
      baud_nxt = pwdata[`CTRL_BAUD_HI:`CTRL_BAUD_LO];
    if (wr_ctrl && pwdata[`CTRL_PAR_HI:`CTRL_PAR_LO] inside {PAR_NONE, PAR_EVEN, PAR_ODD})
      par_nxt = parity_t'(pwdata[`CTRL_PAR_HI:`CTRL_PAR_LO]);
    talk_nxt = ((talk_r && !done_last) || (wr_ctrl && pwdata[`CTRL_TALK])) && !is_etx;
    nl_nxt = ((nl_r && !done_last) || (talk_r && push && is_nl)) && !is_etx;
    abort_nxt = (abort_r && !(wr_stat && pwdata[`ST_ABORT])) || is_etx;
    ovr_nxt = (ovr_r && !(wr_stat && pwdata[`ST_OVR]))
              || (rx_vld && !rx_ferr && !is_etx && !push);
    perr_nxt = (perr_r && !(wr_stat && pwdata[`ST_PERR])) || (rx_vld && rx_perr);
    ferr_nxt = (ferr_r && !(wr_stat && pwdata[`ST_FERR])) || (rx_vld && rx_ferr);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      baud_r <= `CTRL_RST_BAUD;
      par_r <= PAR_NONE;
      talk_r <= 1'b0;
      nl_r <= 1'b0;
      abort_r <= 1'b0;
      ovr_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      baud_r <= baud_nxt;
      par_r <= par_nxt;
      talk_r <= talk_nxt;
      nl_r <= nl_nxt;
      abort_r <= abort_nxt;
      ovr_r <= ovr_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata <= prdata_nxt;
    end
  end

  // receive buffer and DTR; Ctrl-C is consumed, never stored
  always_comb
  begin
    may_take = dtr || (grace_r < GRACE_C);
    push = rx_vld && !rx_ferr && !is_etx && may_take && (cnt_r != DEPTH_C);
    pop = rd_rx && prdata[`RXD_VALID];
    wp_nxt = wp_r + {{(PW-1){1'b0}}, push};
    rp_nxt = rp_r + {{(PW-1){1'b0}}, pop};
    cnt_nxt = cnt_r + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
    // hysteresis keeps DTR from chattering around the threshold
    if (cnt_r >= FULL_C)
      fill_nxt = 1'b1;
    else if (cnt_r <= RESUME_C)
      fill_nxt = 1'b0;
    else
      fill_nxt = fill_r;
    // chars after DTR drops are counted; past the grace allowance they are dropped
    if (dtr)
      grace_nxt = '0;
    else if (push && grace_r != 4'hf)
      grace_nxt = grace_r + 1'b1;
    else
      grace_nxt = grace_r;
    dtr_nxt = !(fill_r || talk_hold || susp_r);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      fill_r <= 1'b0;
      grace_r <= '0;
      dtr <= 1'b0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      fill_r <= fill_nxt;
      grace_r <= grace_nxt;
      dtr <= dtr_nxt;
    end
    if (push)
      mem_r[wp_r] <= char_in;
  end

  // transmitter: start bit, 8 slots, two stop bits, LSB first
  always_comb
  begin
    // a response may only start once DTR is already low for it
    talk_ok = !talk_r || (talk_hold && !dtr);
    tb_take = (tx_st_r == TX_IDLE) && tb_v && dsr && talk_ok && !is_etx;
    tx_frame_dat = tb_d[7:0];
    if (par_r == PAR_EVEN)
      tx_frame_dat[7] = ^tb_d[6:0];
    else if (par_r == PAR_ODD)
      tx_frame_dat[7] = !(^tb_d[6:0]);
    tx_st_nxt = tx_st_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    tcnt_nxt = tcnt_r;
    last_nxt = last_r;
    txd_nxt = txd;
    done_last = 1'b0;
    // suspend only when a char is waiting and DSR is false; resume picks up the same char
    susp_nxt = (tx_st_r == TX_IDLE) && tb_v && !dsr && !is_etx;
    case (tx_st_r)
      TX_IDLE:
        if (tb_take)
        begin
          tx_st_nxt = TX_SEND;
          sh_nxt = {2'b11, tx_frame_dat, 1'b0};
          txd_nxt = 1'b0;
          idx_nxt = '0;
          tcnt_nxt = bit_cyc - 1'b1;
          last_nxt = tb_d[`TXD_LAST];
        end
      TX_SEND:
        if (is_etx)
        begin
          tx_st_nxt = TX_IDLE;
          txd_nxt = 1'b1;
        end
        else if (tcnt_r != '0)
          tcnt_nxt = tcnt_r - 1'b1;
        else if (idx_r == `TX_FRAME_BITS - 1'b1)
        begin
          tx_st_nxt = TX_IDLE;
          txd_nxt = 1'b1;
          done_last = last_r;
        end
        else
        begin
          sh_nxt = {1'b1, sh_r[10:1]};
          txd_nxt = sh_r[1];
          idx_nxt = idx_r + 1'b1;
          tcnt_nxt = bit_cyc - 1'b1;
        end
      default:
      begin
        tx_st_nxt = TX_IDLE;
        txd_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tx_st_r <= TX_IDLE;
      sh_r <= '1;
      idx_r <= '0;
      tcnt_r <= '0;
      last_r <= 1'b0;
      txd <= 1'b1;
      susp_r <= 1'b0;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      tcnt_r <= tcnt_nxt;
      last_r <= last_nxt;
      txd <= txd_nxt;
      susp_r <= susp_nxt;
    end
  end
endmodule : serial_flow_ctrl

// ===== pkg/serial_pkg.sv
/*
  types shared by the serial flow-control block.
  assumes: compiled before every design file.
*/
package serial_pkg;
  typedef logic [19:0] bitcnt_t;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} parity_t;
  typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} tx_state_t;
endpackage : serial_pkg

// ===== pkg/serial_regs.svh
/*
  serial flow-control block: register offsets, field positions, reset values,
  special characters and timing figures.
  assumes: included by bare name; holds definitions only.
*/
`ifndef SERIAL_REGS_SVH
`define SERIAL_REGS_SVH

`define CLK_HZ        125000000
`define BAUD_FAST     9600
`define BAUD_SEL_MAX  3'h5
`define APB_AW        12

`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_RXDATA    12'h008
`define OFF_TXDATA    12'h00c

`define CTRL_BAUD_LO  0
`define CTRL_BAUD_HI  2
`define CTRL_PAR_LO   3
`define CTRL_PAR_HI   4
`define CTRL_TALK     5
`define CTRL_RST_BAUD 3'h5

`define ST_CNT_LO     0
`define ST_CNT_HI     7
`define ST_DTR        8
`define ST_SUSP       9
`define ST_TXRDY      10
`define ST_TALK       11
`define ST_ABORT      12
`define ST_OVR        13
`define ST_PERR       14
`define ST_FERR       15

`define RXD_VALID     8
`define TXD_LAST      8

`define CHAR_NL       8'h0a
`define CHAR_ETX      8'h03

`define FULL_LEVEL    100
`define RESUME_LEVEL  90
`define GRACE_CHARS   10
`define FIFO_DEPTH    128
`define TX_FRAME_BITS 4'hb

`endif
